/* File: dv/mpr_i2c_host.sv */
/*
  Serial bus host model: start, stop, byte slots and whole register
  reads and writes. Assumes the data wire is pulled up outside.
*/
`timescale 1ns/1ps
`default_nettype none
module mpr_i2c_host #(
	parameter int QTR = 313 // quarter of a 100 kHz bit at 125 MHz
) (
	// bench clock
	input wire logic core_clk,
	// bus wires
	input wire logic sda_in,
	output logic scl,
	output logic sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// data moves only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		sda_low <= !b;
		tick(QTR);
		scl <= 1'b1;
		tick(2 * QTR);
		r = sda_in;
		scl <= 1'b0;
		tick(QTR);
	endtask
	task automatic start();
		sda_low <= 1'b0;
		tick(QTR);
		scl <= 1'b1;
		tick(QTR);
		sda_low <= 1'b1;
		tick(QTR);
		scl <= 1'b0;
		tick(QTR);
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		tick(QTR);
		scl <= 1'b1;
		tick(QTR);
		sda_low <= 1'b0;
		tick(4 * QTR);
	endtask
	// top bit first, then the ninth slot (low means acknowledged)
	task automatic xbyte(input logic [7:0] b, input logic nine,
		output logic [7:0] r, output logic ack_n);
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r[i]);
		end
		bit_io(nine, ack_n);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] cmd,
		input logic [55:0] d, input int n, output logic nak);
		logic [7:0] r;
		logic k;
		start();
		xbyte({a, 1'b0}, 1'b1, r, nak);
		if (!nak) begin
			xbyte(cmd, 1'b1, r, k);
			for (int i = 0; i < n; i++) begin
				xbyte(d[8 * i +: 8], 1'b1, r, k);
			end
		end
		stop();
	endtask
	// last byte refused so the device lets go of the line
	task automatic rd(input logic [6:0] a, input logic [7:0] cmd,
		output logic [55:0] d);
		logic [7:0] r;
		logic k;
		start();
		xbyte({a, 1'b0}, 1'b1, r, k);
		xbyte(cmd, 1'b1, r, k);
		start();
		xbyte({a, 1'b1}, 1'b1, r, k);
		for (int i = 0; i < 7; i++) begin
			xbyte(8'hff, i == 6, r, k);
			d[8 * i +: 8] = r;
		end
		stop();
	endtask
endmodule
`default_nettype wire

/* File: dv/mpr_regbank_asserts.sv */
/*
  Port checker of the register bank: data-line timing, control output
  reset and update moments, clock-enable freeze and snapshot handshake.
  Assumes the serial clock keeps low phases of at least ten core cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module mpr_regbank_asserts
	import mpr_pkg::*;
#(
	parameter logic [3:0] DEV_ADDR_HI = 4'h0
) (
	// core side
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	// snapshot side
	input wire logic meas_clk,
	input wire logic meas_rst,
	input wire logic meas_valid,
	input wire mpr_pkg::mpr_snap_s meas_data,
	input wire logic meas_ready,
	// serial pins
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic [2:0] addr_pins,
	// status pins and settings
	input wire logic otemp_n_pin,
	input wire logic overvoltage_input,
	input wire logic bypass_request_pin,
	input wire mpr_pkg::mpr_ctl_s ctl_ff
);
	// a snapshot offered and taken at one edge
	sequence s_take;
		meas_valid && meas_ready;
	endsequence
	a_sda_low: assert property (
		@(posedge core_clk) disable iff (rst) sda_o == 1'b0
	) else $error("data output driven high");
	a_oe_window: assert property (
		@(posedge core_clk) disable iff (rst)
		$changed(sda_oe) |-> !scl_i && !$past(scl_i, 2)
	) else $error("data line moved while clock high");
	a_oe_hold: assert property (
		@(posedge core_clk) disable iff (rst) $rose(sda_oe) |-> sda_oe[*8]
	) else $error("data pull dropped too soon");
	a_ctl_reset: assert property (
		@(posedge core_clk) disable iff (rst) $fell(rst) && $past(ce) |->
		ctl_ff.duty == 9'h0ff && ctl_ff.tdon == 3'h3 &&
		ctl_ff.tdoff == 3'h3 && !ctl_ff.clk_out_en && !ctl_ff.override
	) else $error("settings not at reset values");
	a_ctl_by_bus: assert property (
		@(posedge core_clk) disable iff (rst)
		$changed({ctl_ff.override, ctl_ff.duty, ctl_ff.tdoff, ctl_ff.tdon,
			ctl_ff.clk_out_en, ctl_ff.soft_reset, ctl_ff.open_loop})
		|-> !scl_i && !$past(scl_i, 3)
	) else $error("settings changed outside a write");
	a_ce_freeze: assert property (
		@(posedge core_clk) disable iff (rst)
		!ce |=> $stable(ctl_ff) && $stable(sda_oe)
	) else $error("state moved while clock enable low");
	a_ready_drop: assert property (
		@(posedge meas_clk) disable iff (meas_rst) s_take |=> !meas_ready
	) else $error("snapshot ready stayed high after take");
	a_ready_back: assert property (
		@(posedge meas_clk) disable iff (meas_rst)
		s_take |-> ##[2:12] meas_ready
	) else $error("snapshot ready did not return");
endmodule
bind mpr_regbank mpr_regbank_asserts #(.DEV_ADDR_HI(DEV_ADDR_HI)) u_chk (
	.core_clk(core_clk), .rst(rst), .ce(ce), .meas_clk(meas_clk),
	.meas_rst(meas_rst), .meas_valid(meas_valid), .meas_data(meas_data),
	.meas_ready(meas_ready), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe(sda_oe), .addr_pins(addr_pins), .otemp_n_pin(otemp_n_pin),
	.overvoltage_input(overvoltage_input),
	.bypass_request_pin(bypass_request_pin), .ctl_ff(ctl_ff)
);
`default_nettype wire

/* File: dv/mpr_regbank_test.sv */
/*
  Bench of the register bank: snapshots on their own clock, register
  traffic through the host model. Assumes the model and checker exist.
*/
`timescale 1ns/1ps
`default_nettype none
module mpr_regbank_test;
	import mpr_pkg::*;
	localparam logic [6:0] ADDR = 7'h05;
	logic core_clk, rst, ce, meas_clk, meas_rst, meas_valid, nak;
	logic meas_ready, scl, sda_low, sda_o, sda_oe, otemp_n, ovp_n, byp_n;
	mpr_snap_s meas_data, snap;
	mpr_ctl_s ctl_ff;
	logic [55:0] d, wv;
	logic [42:0] exp_ctl;
	int mismatches, total_checks;
	wire logic sda = !(sda_low | sda_oe); // pull-up unless pulled
	mpr_regbank u_mpr_regbank (
		.core_clk(core_clk), .rst(rst), .ce(ce), .meas_clk(meas_clk),
		.meas_rst(meas_rst), .meas_valid(meas_valid), .meas_data(meas_data),
		.meas_ready(meas_ready), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe), .addr_pins(ADDR[2:0]), .otemp_n_pin(otemp_n),
		.overvoltage_input(ovp_n), .bypass_request_pin(byp_n),
		.ctl_ff(ctl_ff)
	);
	// bit time cut well below the standard rate so the run stays short;
	// low phases still sit far above the design's synchroniser delay
	mpr_i2c_host #(.QTR(10)) u_mpr_i2c_host (.core_clk(core_clk),
		.sda_in(sda), .scl(scl), .sda_low(sda_low));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = !core_clk;
	end
	// link clock offset so its edges never meet the core edges
	initial begin
		meas_clk = 1'b0;
		#3;
		forever #40 meas_clk = !meas_clk;
	end
	task automatic chk(input string what, input logic [55:0] seen,
		input logic [55:0] want);
		total_checks++;
		if (seen !== want) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// hold the snapshot until the bank takes it
	task automatic send_snap(input mpr_snap_s s);
		int n = 0;
		@(posedge meas_clk);
		meas_data <= s;
		meas_valid <= 1'b1;
		do begin
			@(posedge meas_clk);
			n++;
		end while (meas_ready !== 1'b1 && n < 50);
		meas_valid <= 1'b0;
	endtask
	initial begin
		repeat (90000) @(posedge core_clk);
		mismatches++;
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		meas_rst = 1'b1;
		ce = 1'b1;
		meas_valid = 1'b0;
		meas_data = '0;
		otemp_n = 1'b1;
		ovp_n = 1'b1;
		byp_n = 1'b1;
		mismatches = 0;
		total_checks = 0;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge meas_clk);
		meas_rst <= 1'b0;
		repeat (4) @(posedge core_clk);
		// idle pins read high in the status bits
		u_mpr_i2c_host.rd(ADDR, CMD_BASE + IDX_CHAN, d);
		chk("chan", d, '0);
		u_mpr_i2c_host.rd(ADDR, CMD_BASE + IDX_MEAS, d);
		chk("stat", d, 56'h3 << 41);
		u_mpr_i2c_host.rd(ADDR, CMD_BASE + IDX_CTRL, d);
		wv = {16'h0, 10'h3ff, 10'h3ff, 3'h3, 3'h3, 9'h0ff, 5'h0};
		chk("ctrl", d, wv);
		$display("test reset values done");
		snap = '{1'b1, 10'h288, 10'h177, 10'h2a6, 10'h155, 10'h044,
			10'h033, 10'h022, 10'h011};
		otemp_n <= 1'b0;
		send_snap(snap);
		u_mpr_i2c_host.rd(ADDR, CMD_BASE + IDX_CHAN, d);
		chk("chan", d, {16'h0, snap[79:40]});
		u_mpr_i2c_host.rd(ADDR, CMD_BASE + IDX_MEAS, d);
		chk("stat", d, {13'h0, 2'b01, snap[80], snap[39:0]});
		// swap the two fault pins so a stuck or crossed bit shows up
		otemp_n <= 1'b1;
		ovp_n <= 1'b0;
		u_mpr_i2c_host.rd(ADDR, CMD_BASE + IDX_MEAS, d);
		chk("stat", d, {13'h0, 2'b10, snap[80], snap[39:0]});
		$display("test snapshot done");
		// reserved bits set on purpose, they must read back as zero
		wv = {9'h1ff, 1'b1, 3'h7, 1'b1, 2'h2, 10'h2c1, 10'h1d2, 3'h5, 3'h6,
			9'h1a5, 5'h1a};
		u_mpr_i2c_host.wr(ADDR, CMD_BASE + IDX_CTRL, wv, 7, nak);
		u_mpr_i2c_host.rd(ADDR, CMD_BASE + IDX_CTRL, d);
		chk("ctrl", d, {9'h0, 1'b1, 3'h0, wv[42:0]});
		chk("ctl", 56'(ctl_ff), 56'({wv[46], wv[42:5], 4'b1100}));
		wv[46] = 1'b0;
		wv[4:0] = 5'h0;
		byp_n <= 1'b0;
		u_mpr_i2c_host.wr(ADDR, CMD_BASE + IDX_CTRL, wv, 7, nak);
		exp_ctl = {1'b0, snap.ch2[9:7], snap.ch4, snap.ch0, wv[19:5], 4'h8};
		chk("ctl", 56'(ctl_ff), 56'(exp_ctl));
		$display("test override done");
		u_mpr_i2c_host.wr(ADDR, CMD_BASE + IDX_CTRL, '0, 3, nak);
		u_mpr_i2c_host.wr(ADDR, CMD_BASE + 8'h02, '1, 7, nak);
		u_mpr_i2c_host.wr(ADDR ^ 7'h01, CMD_BASE + IDX_CTRL, '0, 7, nak);
		chk("nak", 56'(nak), 56'h1);
		u_mpr_i2c_host.rd(ADDR, CMD_BASE + 8'h02, d);
		chk("unmapped", d, '0);
		u_mpr_i2c_host.rd(ADDR, CMD_BASE + IDX_CTRL, d);
		chk("ctrl", d, {9'h0, 1'b0, 3'h0, wv[42:0]});
		$display("test refusals done");
		wv[0] = 1'b1;
		u_mpr_i2c_host.wr(ADDR, CMD_BASE + IDX_CTRL, wv, 7, nak);
		u_mpr_i2c_host.wr(ADDR, CMD_BASE + IDX_CTRL, wv | 56'h4, 7, nak);
		chk("soft", 56'({ctl_ff.soft_reset, ctl_ff.open_loop}), 56'h3);
		u_mpr_i2c_host.wr(ADDR, CMD_BASE + IDX_CTRL, wv, 7, nak);
		// a pin change while frozen must not reach the settings
		ce <= 1'b0;
		byp_n <= 1'b1;
		repeat (6) @(posedge core_clk);
		chk("frozen", 56'(ctl_ff.bypass_req), 56'h1);
		ce <= 1'b1;
		repeat (6) @(posedge core_clk);
		chk("thawed", 56'(ctl_ff.bypass_req), 56'h0);
		chk("open", 56'({ctl_ff.soft_reset, ctl_ff.duty}), 56'h1a5);
		$display("test open loop done");
		print_verdict();
	end
endmodule
`default_nettype wire

/* File: rtl/mpr_pkg.sv */
/*
  Shared constants and carrier types of the tracking controller register
  bank: command codes, field positions, reset values and the snapshot and
  control structs. Assumes nothing beyond a SystemVerilog compiler.
*/
package mpr_pkg;

	// register geometry
	localparam int REG_W = 56;
	localparam int FLD_W = 10;
	localparam logic [3:0] REG_BYTES = 4'h7;

	// command byte: base plus register number
	localparam logic [7:0] CMD_BASE = 8'he0;
	localparam logic [7:0] IDX_CHAN = 8'h00;
	localparam logic [7:0] IDX_MEAS = 8'h01;
	localparam logic [7:0] IDX_CTRL = 8'h03;

	// channel reading register
	localparam int CH0_LSB = 0;
	localparam int CH2_LSB = 10;
	localparam int CH4_LSB = 20;
	localparam int CH6_LSB = 30;

	// measurement and status register
	localparam int IIN_LSB = 0;
	localparam int VIN_LSB = 10;
	localparam int IOUT_LSB = 20;
	localparam int VOUT_LSB = 30;
	localparam int TRACK_BIT = 40;
	localparam int OVP_BIT = 41;
	localparam int OTEMP_BIT = 42;

	// control register
	localparam int OPEN_LOOP_BIT = 0;
	localparam int CLK_OE_BIT = 1;
	localparam int SOFT_RST_BIT = 2;
	localparam int BYP_MAN_BIT = 3;
	localparam int BYP_SEL_BIT = 4;
	localparam int DUTY_LSB = 5;
	localparam int TDON_LSB = 14;
	localparam int TDOFF_LSB = 17;
	localparam int VMAX_LSB = 20;
	localparam int IMAX_LSB = 30;
	localparam int BB_LSB = 40;
	localparam int PTHR_BIT = 42;
	localparam int OVR_BIT = 46;

	// bits of channel 2 that the override replaces
	localparam int CH2_BB_LSB = 7;
	localparam int CH2_PTHR_BIT = 9;

	// control reset values
	localparam logic [9:0] MAX_RST = 10'h3ff;
	localparam logic [2:0] DT_RST = 3'h3;
	localparam logic [8:0] DUTY_RST = 9'h0ff;
	localparam logic [55:0] CTRL_RST = (56'(MAX_RST) << IMAX_LSB)
		| (56'(MAX_RST) << VMAX_LSB) | (56'(DT_RST) << TDOFF_LSB)
		| (56'(DT_RST) << TDON_LSB) | (56'(DUTY_RST) << DUTY_LSB);
	// writable bits: 46 and 42:0, the rest read as zero
	localparam logic [55:0] CTRL_WMASK = 56'h00_47ff_ffff_ffff;

	// one conversion snapshot from the measurement side
	typedef struct packed {
		logic track_start;
		logic [9:0] ch6;
		logic [9:0] ch4;
		logic [9:0] ch2;
		logic [9:0] ch0;
		logic [9:0] vout;
		logic [9:0] iout;
		logic [9:0] vin;
		logic [9:0] iin;
	} mpr_snap_s;

	// settings handed to the converter logic
	typedef struct packed {
		logic override;
		logic pthr_sel;
		logic [1:0] bb_sel;
		logic [9:0] iout_max;
		logic [9:0] vout_max;
		logic [2:0] tdoff;
		logic [2:0] tdon;
		logic [8:0] duty;
		logic bypass_req;
		logic clk_out_en;
		logic soft_reset;
		logic open_loop;
	} mpr_ctl_s;

endpackage

/* File: rtl/mpr_regbank.sv */
/*
  Register bank of the tracking controller behind a two-wire serial slave:
  channel readings, measurement status and the control register, plus the
  settings derived from them. Assumes scl/sda and the status pins are
  asynchronous, and the snapshot arrives on its own measurement clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mpr_regbank #(
	parameter logic [3:0] DEV_ADDR_HI = 4'h0
) (
	// core clock, reset and clock enable
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	// measurement snapshot on its own clock
	input wire logic meas_clk,
	input wire logic meas_rst,
	input wire logic meas_valid,
	input wire mpr_pkg::mpr_snap_s meas_data,
	output logic meas_ready,
	// serial port pins, open drain data
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic [2:0] addr_pins,
	// status and request pins, active low
	input wire logic otemp_n_pin,
	input wire logic overvoltage_input,
	input wire logic bypass_request_pin,
	// settings to the converter
	output mpr_pkg::mpr_ctl_s ctl_ff
);
	import mpr_pkg::*;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_RX = 5'b00010,
		ST_ACK = 5'b00100,
		ST_TX = 5'b01000,
		ST_RACK = 5'b10000
	} mpr_state_e;

	typedef enum logic [2:0] {
		PH_ADDR = 3'b001,
		PH_CMD = 3'b010,
		PH_DATA = 3'b100
	} mpr_phase_e;

	localparam int NPIN = 8;

	logic [NPIN-1:0] pin_s1_ff, pin_s2_ff;
	logic scl_p_ff, sda_p_ff;
	logic scl_s, sda_s, otemp_s, ovp_s, byp_s;
	logic [2:0] addr_s;
	logic start_c, stop_c, rise_c, fall_c;
	mpr_state_e st_ff;
	mpr_phase_e ph_ff;
	logic [3:0] cnt_ff;
	logic [7:0] sh_ff, tx_ff, cmd_ff;
	logic [3:0] widx_ff;
	logic [7:0] wbuf [0:6];
	logic rw_ff, nack_ff, commit_ff;
	logic [55:0] rd_ff, chan_ff, stat_ff, ctrl_ff;
	logic snap_valid;
	mpr_snap_s snap_data;

	// snapshot crossing from the measurement clock
	mpr_snap_cdc u_cdc (
		.meas_clk(meas_clk),
		.meas_rst(meas_rst),
		.meas_valid(meas_valid),
		.meas_data(meas_data),
		.meas_ready(meas_ready),
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.snap_valid(snap_valid),
		.snap_data(snap_data)
	);

	// register contents selected by a command byte
	function automatic logic [55:0] reg_read(input logic [7:0] cmd,
		input logic [55:0] chan, input logic [55:0] stat,
		input logic [55:0] ctrl);
		if (cmd == CMD_BASE + IDX_CHAN)
			reg_read = chan;
		else if (cmd == CMD_BASE + IDX_MEAS)
			reg_read = stat;
		else if (cmd == CMD_BASE + IDX_CTRL)
			reg_read = ctrl;
		else
			reg_read = '0;
	endfunction

	// two-stage synchronisers for every asynchronous pin
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pin_s1_ff <= '1;
			pin_s2_ff <= '1;
		end else if (ce) begin
			pin_s1_ff <= {addr_pins, otemp_n_pin, overvoltage_input,
				bypass_request_pin, scl_i, sda_i};
			pin_s2_ff <= pin_s1_ff;
		end
	end

	assign addr_s = pin_s2_ff[7:5];
	assign otemp_s = pin_s2_ff[4];
	assign ovp_s = pin_s2_ff[3];
	assign byp_s = pin_s2_ff[2];
	assign scl_s = pin_s2_ff[1];
	assign sda_s = pin_s2_ff[0];

	// previous line levels for edge and framing detection
	always_ff @(posedge core_clk) begin
		if (rst) begin
			scl_p_ff <= 1'b1;
			sda_p_ff <= 1'b1;
		end else if (ce) begin
			scl_p_ff <= scl_s;
			sda_p_ff <= sda_s;
		end
	end

	assign start_c = scl_s & scl_p_ff & sda_p_ff & ~sda_s;
	assign stop_c = scl_s & scl_p_ff & ~sda_p_ff & sda_s;
	assign rise_c = scl_s & ~scl_p_ff;
	assign fall_c = ~scl_s & scl_p_ff;

	// data line only ever pulls low
	always_ff @(posedge core_clk) begin
		sda_o <= 1'b0;
	end

	// serial slave: bits taken on clock rise, data line moved on fall
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_ff <= ST_IDLE;
			ph_ff <= PH_ADDR;
			cnt_ff <= '0;
			sh_ff <= '0;
			tx_ff <= '0;
			cmd_ff <= '0;
			widx_ff <= '0;
			rw_ff <= 1'b0;
			nack_ff <= 1'b0;
			commit_ff <= 1'b0;
			sda_oe <= 1'b0;
			rd_ff <= '0;
		end else if (ce) begin
			commit_ff <= 1'b0;
			if (start_c) begin
				// repeated start keeps the command for the read that follows
				st_ff <= ST_RX;
				ph_ff <= PH_ADDR;
				cnt_ff <= '0;
				sda_oe <= 1'b0;
			end else if (stop_c) begin
				st_ff <= ST_IDLE;
				sda_oe <= 1'b0;
			end else if (rise_c) begin
				if (st_ff == ST_RX) begin
					sh_ff <= {sh_ff[6:0], sda_s};
					cnt_ff <= cnt_ff + 4'h1;
				end
				if (st_ff == ST_RACK)
					nack_ff <= sda_s;
			end else if (fall_c) begin
				unique case (st_ff)
				ST_IDLE: begin
				end
				ST_RX: begin
					if (cnt_ff == 4'h8) begin
						cnt_ff <= '0;
						unique case (ph_ff)
						PH_ADDR: begin
							if (sh_ff[7:1] == {DEV_ADDR_HI, addr_s}) begin
								rw_ff <= sh_ff[0];
								sda_oe <= 1'b1;
								st_ff <= ST_ACK;
								// snapshot keeps the seven bytes coherent
								rd_ff <= reg_read(cmd_ff, chan_ff, stat_ff,
									ctrl_ff);
							end else begin
								st_ff <= ST_IDLE;
							end
						end
						PH_CMD: begin
							cmd_ff <= sh_ff;
							widx_ff <= '0;
							sda_oe <= 1'b1;
							st_ff <= ST_ACK;
						end
						PH_DATA: begin
							if (widx_ff < REG_BYTES) begin
								wbuf[widx_ff[2:0]] <= sh_ff;
								widx_ff <= widx_ff + 4'h1;
								sda_oe <= 1'b1;
								st_ff <= ST_ACK;
								if (widx_ff == REG_BYTES - 4'h1 &&
									cmd_ff == CMD_BASE + IDX_CTRL)
									commit_ff <= 1'b1;
							end else begin
								st_ff <= ST_IDLE; // eighth byte refused
							end
						end
						default: st_ff <= ST_IDLE;
						endcase
					end
				end
				ST_ACK: begin
					if (rw_ff) begin
						// least significant byte leaves first
						tx_ff <= rd_ff[7:0];
						rd_ff <= rd_ff >> 8;
						sda_oe <= ~rd_ff[7];
						cnt_ff <= 4'h1;
						st_ff <= ST_TX;
					end else begin
						sda_oe <= 1'b0;
						st_ff <= ST_RX;
						if (ph_ff == PH_ADDR)
							ph_ff <= PH_CMD;
						else
							ph_ff <= PH_DATA;
					end
				end
				ST_TX: begin
					if (cnt_ff == 4'h8) begin
						sda_oe <= 1'b0;
						st_ff <= ST_RACK;
					end else begin
						sda_oe <= ~tx_ff[6];
						tx_ff <= {tx_ff[6:0], 1'b0};
						cnt_ff <= cnt_ff + 4'h1;
					end
				end
				ST_RACK: begin
					if (nack_ff) begin
						st_ff <= ST_IDLE;
					end else begin
						tx_ff <= rd_ff[7:0];
						rd_ff <= rd_ff >> 8;
						sda_oe <= ~rd_ff[7];
						cnt_ff <= 4'h1;
						st_ff <= ST_TX;
					end
				end
				default: st_ff <= ST_IDLE;
				endcase
			end
		end
	end

	// channel readings follow each snapshot
	always_ff @(posedge core_clk) begin
		if (rst) begin
			chan_ff <= '0;
		end else if (ce && snap_valid) begin
			chan_ff <= '0;
			chan_ff[CH0_LSB +: FLD_W] <= snap_data.ch0;
			chan_ff[CH2_LSB +: FLD_W] <= snap_data.ch2;
			chan_ff[CH4_LSB +: FLD_W] <= snap_data.ch4;
			chan_ff[CH6_LSB +: FLD_W] <= snap_data.ch6;
		end
	end

	// measurements from snapshots, protection pins tracked every cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			stat_ff <= '0;
		end else if (ce) begin
			stat_ff[OTEMP_BIT] <= otemp_s;
			stat_ff[OVP_BIT] <= ovp_s;
			if (snap_valid) begin
				stat_ff[TRACK_BIT] <= snap_data.track_start;
				stat_ff[IIN_LSB +: FLD_W] <= snap_data.iin;
				stat_ff[VIN_LSB +: FLD_W] <= snap_data.vin;
				stat_ff[IOUT_LSB +: FLD_W] <= snap_data.iout;
				stat_ff[VOUT_LSB +: FLD_W] <= snap_data.vout;
			end
		end
	end

	// control register: only a complete seven-byte write lands
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_ff <= CTRL_RST;
		end else if (ce && commit_ff) begin
			ctrl_ff <= {wbuf[6], wbuf[5], wbuf[4], wbuf[3], wbuf[2],
				wbuf[1], wbuf[0]} & CTRL_WMASK;
		end
	end

	// settings for the converter, registered so outputs never glitch
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctl_ff <= '0;
			ctl_ff.iout_max <= MAX_RST;
			ctl_ff.vout_max <= MAX_RST;
			ctl_ff.tdoff <= DT_RST;
			ctl_ff.tdon <= DT_RST;
			ctl_ff.duty <= DUTY_RST;
		end else if (ce) begin
			ctl_ff.override <= ctrl_ff[OVR_BIT];
			if (ctrl_ff[OVR_BIT]) begin
				ctl_ff.pthr_sel <= ctrl_ff[PTHR_BIT];
				ctl_ff.bb_sel <= ctrl_ff[BB_LSB +: 2];
				ctl_ff.iout_max <= ctrl_ff[IMAX_LSB +: FLD_W];
				ctl_ff.vout_max <= ctrl_ff[VMAX_LSB +: FLD_W];
			end else begin
				ctl_ff.pthr_sel <= chan_ff[CH2_LSB + CH2_PTHR_BIT];
				ctl_ff.bb_sel <= chan_ff[CH2_LSB + CH2_BB_LSB +: 2];
				ctl_ff.iout_max <= chan_ff[CH4_LSB +: FLD_W];
				ctl_ff.vout_max <= chan_ff[CH0_LSB +: FLD_W];
			end
			ctl_ff.tdoff <= ctrl_ff[TDOFF_LSB +: 3];
			ctl_ff.tdon <= ctrl_ff[TDON_LSB +: 3];
			ctl_ff.duty <= ctrl_ff[DUTY_LSB +: 9];
			// the pin requests bypass when low; register bit is active high
			if (ctrl_ff[BYP_SEL_BIT])
				ctl_ff.bypass_req <= ctrl_ff[BYP_MAN_BIT];
			else
				ctl_ff.bypass_req <= ~byp_s;
			ctl_ff.clk_out_en <= ctrl_ff[CLK_OE_BIT];
			ctl_ff.soft_reset <= ctrl_ff[SOFT_RST_BIT];
			ctl_ff.open_loop <= ctrl_ff[OPEN_LOOP_BIT];
		end
	end
endmodule
`default_nettype wire

/* File: rtl/mpr_snap_cdc.sv */
/*
  Carries one measurement snapshot from the measurement clock into the core
  clock with a toggle handshake. Assumes the producer holds meas_valid until
  it sees meas_ready high, and that both resets are synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module mpr_snap_cdc (
	// measurement domain
	input wire logic meas_clk,
	input wire logic meas_rst,
	input wire logic meas_valid,
	input wire mpr_pkg::mpr_snap_s meas_data,
	output logic meas_ready,
	// core domain
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	output logic snap_valid,
	output mpr_pkg::mpr_snap_s snap_data
);
	import mpr_pkg::*;

	mpr_snap_s hold_ff;
	logic req_tog_ff;
	logic ack_s1_ff, ack_s2_ff;
	logic req_s1_ff, req_s2_ff, req_s3_ff;
	logic ack_tog_ff;

	// producer side: hold stays still until the core returns the toggle
	always_ff @(posedge meas_clk) begin
		if (meas_rst) begin
			hold_ff <= '0;
			req_tog_ff <= 1'b0;
			meas_ready <= 1'b0;
		end else if (meas_ready && meas_valid) begin
			hold_ff <= meas_data;
			req_tog_ff <= ~req_tog_ff;
			meas_ready <= 1'b0;
		end else begin
			meas_ready <= (ack_s2_ff == req_tog_ff);
		end
	end

	// acknowledge back into the measurement clock
	always_ff @(posedge meas_clk) begin
		if (meas_rst) begin
			ack_s1_ff <= 1'b0;
			ack_s2_ff <= 1'b0;
		end else begin
			ack_s1_ff <= ack_tog_ff;
			ack_s2_ff <= ack_s1_ff;
		end
	end

	// core side: a toggle edge means hold_ff is settled and safe to take
	always_ff @(posedge core_clk) begin
		if (rst) begin
			req_s1_ff <= 1'b0;
			req_s2_ff <= 1'b0;
			req_s3_ff <= 1'b0;
			ack_tog_ff <= 1'b0;
			snap_valid <= 1'b0;
			snap_data <= '0;
		end else if (ce) begin
			req_s1_ff <= req_tog_ff;
			req_s2_ff <= req_s1_ff;
			req_s3_ff <= req_s2_ff;
			snap_valid <= (req_s2_ff != req_s3_ff);
			if (req_s2_ff != req_s3_ff) begin
				snap_data <= hold_ff;
				ack_tog_ff <= req_s2_ff;
			end
		end
	end
endmodule
`default_nettype wire
